// >>> shared/temp_monitor_map.svh
// constants of the background temperature monitor: resets, codes, scaling
`ifndef TEMP_MONITOR_MAP_SVH
`define TEMP_MONITOR_MAP_SVH

// result code width and ideality correction width
`define TM_RESULT_W 12
`define TM_CORR_W 8

// reset values
`define TM_RESULT_RESET 12'h000
`define TM_IDEALITY_RESET 8'h00

// sensor indices in scan order
`define TM_SENSOR_LOCAL 2'h0
`define TM_SENSOR_REMOTE_ONE 2'h1
`define TM_SENSOR_REMOTE_TWO 2'h2
`define TM_SENSOR_NONE 2'h3

// ideality scaling: eta_eff = 1.008 * base / (base - correction)
`define TM_IDEALITY_BASE 10'sh12c
// 273.15 degrees in eighths of a degree, rounded to whole codes
`define TM_KELVIN_OFFSET 14'sh0889

// saturation limits of a 12-bit two's complement code
`define TM_CODE_MAX 12'h7ff
`define TM_CODE_MIN 12'h800

`endif

// >>> shared/temp_monitor_pkg.sv
// types shared by the temperature monitor modules
package temp_monitor_pkg;

	typedef logic [1:0] sensor_t;
	typedef logic [11:0] temp_code_t;

	typedef enum logic [2:0] {
		ST_SELECT,
		ST_LAUNCH,
		ST_WAIT,
		ST_SCALE
	} scan_state_e;

endpackage

// >>> logic/ideality_scale.sv
// rescales a raw remote reading for a corrected ideality factor
`timescale 1ns/1ps
`default_nettype none
`include "temp_monitor_map.svh"

module ideality_scale #(
	parameter int CODE_W = 12,
	parameter int CORR_W = 8
) (
	input wire logic [CODE_W-1:0] code_raw,
	input wire logic [CORR_W-1:0] correction,
	input wire logic apply,
	output logic [CODE_W-1:0] code_out
);

	// the arithmetic below is sized for these widths only
	if (CODE_W != 12 || CORR_W != 8) begin : g_bad_width
		$error("ideality_scale supports only 12-bit codes, 8-bit correction");
	end

	logic signed [13:0] kelvin;
	logic signed [9:0] factor;
	logic signed [23:0] prod;
	logic signed [23:0] quot;
	logic signed [23:0] celsius;

	// the reading scales with 1/eta, which must be done in kelvin
	always_comb begin
		kelvin = $signed({{2{code_raw[11]}}, code_raw}) + `TM_KELVIN_OFFSET;
		factor = `TM_IDEALITY_BASE - $signed({{2{correction[7]}}, correction});
		prod = kelvin * factor;
		quot = prod / 24'sd300;
		celsius = quot - $signed({{10{1'b0}}, `TM_KELVIN_OFFSET});
		if (!apply) begin
			code_out = code_raw;
		end else if (celsius > 24'sd2047) begin
			code_out = `TM_CODE_MAX;
		end else if (celsius < -24'sd2048) begin
			code_out = `TM_CODE_MIN;
		end else begin
			code_out = celsius[11:0];
		end
	end

endmodule

`default_nettype wire

// >>> logic/temp_monitor.sv
// background temperature monitor: scan control and result registers
//
// Behaviour
// - only sensors whose enable is set are converted; others are skipped
// - scanning runs on its own, never waiting on primary conversions
// - when a cycle ends the next cycle starts with no software trigger
// - each result lands in its own register: local, remote one, remote two
// - results are 12-bit two's complement, one code is an eighth degree
// - after reset the ideality correction is zero: the trimmed factor
// - remote readings use ideality 1.008*300/(300 - correction)
// - resistance cancellation is active only while its setting is one
// - every result register presents a 12-bit value to the host
// - result registers hold during a host transfer, update after it ends
`timescale 1ns/1ps
`default_nettype none
`include "temp_monitor_map.svh"

module temp_monitor #(
	parameter int RESULT_W = `TM_RESULT_W,
	parameter int CORR_W = `TM_CORR_W
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic local_sensor_enable,
	input wire logic remote_one_enable,
	input wire logic remote_two_enable,
	input wire logic series_resistance_cancel,
	input wire logic ideality_write,
	input wire logic [CORR_W-1:0] ideality_wdata,
	output logic [CORR_W-1:0] ideality_correction,
	input wire logic host_xfer_busy,
	output logic conv_start,
	output logic [1:0] conv_sensor,
	output logic conv_rc_active,
	input wire logic conv_done,
	input wire logic [RESULT_W-1:0] conv_code,
	output logic [RESULT_W-1:0] local_sensor_result,
	output logic [RESULT_W-1:0] remote_sensor_one_result,
	output logic [RESULT_W-1:0] remote_sensor_two_result,
	output logic cycle_done,
	output logic scan_busy
);

	// the scaling path is sized for these widths only
	if (RESULT_W != 12 || CORR_W != 8) begin : g_bad_width
		$error("temp_monitor supports only 12-bit results, 8-bit correction");
	end

	// first enabled sensor at or after 'from', or none
	function automatic temp_monitor_pkg::sensor_t next_enabled(
		input temp_monitor_pkg::sensor_t from,
		input logic [2:0] en
	);
		temp_monitor_pkg::sensor_t pick;
		pick = `TM_SENSOR_NONE;
		for (int i = 2; i >= 0; i--) begin
			if (2'(i) >= from && en[i]) begin
				pick = 2'(i);
			end
		end
		return pick;
	endfunction

	function automatic logic is_remote(input temp_monitor_pkg::sensor_t s);
		return s == `TM_SENSOR_REMOTE_ONE || s == `TM_SENSOR_REMOTE_TWO;
	endfunction

	// ideality correction register
	logic [CORR_W-1:0] corr_q;
	logic [CORR_W-1:0] corr_d;

	always_comb begin
		corr_d = corr_q;
		if (ideality_write) begin
			corr_d = ideality_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			corr_q <= `TM_IDEALITY_RESET;
		end else begin
			corr_q <= corr_d;
		end
	end

	assign ideality_correction = corr_q;

	// scan sequencer
	temp_monitor_pkg::scan_state_e state_q;
	temp_monitor_pkg::scan_state_e state_d;
	temp_monitor_pkg::sensor_t ptr_q;
	temp_monitor_pkg::sensor_t ptr_d;
	temp_monitor_pkg::sensor_t sens_q;
	temp_monitor_pkg::sensor_t sens_d;
	logic rc_q;
	logic rc_d;
	logic any_q;
	logic any_d;
	logic done_q;
	logic done_d;
	logic [RESULT_W-1:0] raw_q;
	logic [RESULT_W-1:0] raw_d;
	logic [2:0] enables;
	temp_monitor_pkg::sensor_t pick;
	logic [RESULT_W-1:0] scaled;

	assign enables = {remote_two_enable, remote_one_enable,
		local_sensor_enable};
	assign pick = next_enabled(ptr_q, enables);

	// the correction only applies to the remote diodes
	ideality_scale #(
		.CODE_W(RESULT_W),
		.CORR_W(CORR_W)
	) u_scale (
		.code_raw(raw_q),
		.correction(corr_q),
		.apply(is_remote(sens_q)),
		.code_out(scaled)
	);

	always_comb begin
		state_d = state_q;
		ptr_d = ptr_q;
		sens_d = sens_q;
		rc_d = rc_q;
		any_d = any_q;
		done_d = 1'b0;
		raw_d = raw_q;
		case (state_q)
			temp_monitor_pkg::ST_SELECT: begin
				// enables are looked at per sensor, so a change takes effect
				// at the next sensor rather than the next cycle
				if (pick == `TM_SENSOR_NONE) begin
					ptr_d = `TM_SENSOR_LOCAL;
					done_d = any_q;
					any_d = 1'b0;
				end else begin
					sens_d = pick;
					rc_d = series_resistance_cancel && is_remote(pick);
					state_d = temp_monitor_pkg::ST_LAUNCH;
				end
			end
			temp_monitor_pkg::ST_LAUNCH: begin
				state_d = temp_monitor_pkg::ST_WAIT;
			end
			temp_monitor_pkg::ST_WAIT: begin
				if (conv_done) begin
					raw_d = conv_code;
					state_d = temp_monitor_pkg::ST_SCALE;
				end
			end
			temp_monitor_pkg::ST_SCALE: begin
				ptr_d = sens_q + 2'h1;
				any_d = 1'b1;
				state_d = temp_monitor_pkg::ST_SELECT;
			end
			default: begin
				state_d = temp_monitor_pkg::ST_SELECT;
				ptr_d = `TM_SENSOR_LOCAL;
			end
		endcase
	end

	// free-running from reset: no trigger starts the scan, only conv_done paces it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q <= temp_monitor_pkg::ST_SELECT;
			ptr_q <= `TM_SENSOR_LOCAL;
			sens_q <= `TM_SENSOR_LOCAL;
			rc_q <= 1'b0;
			any_q <= 1'b0;
			done_q <= 1'b0;
			raw_q <= `TM_RESULT_RESET;
		end else begin
			state_q <= state_d;
			ptr_q <= ptr_d;
			sens_q <= sens_d;
			rc_q <= rc_d;
			any_q <= any_d;
			done_q <= done_d;
			raw_q <= raw_d;
		end
	end

	assign conv_start = state_q == temp_monitor_pkg::ST_LAUNCH;
	assign conv_sensor = sens_q;
	assign conv_rc_active = rc_q;
	assign cycle_done = done_q;
	assign scan_busy = state_q != temp_monitor_pkg::ST_SELECT;

	// result path: a staging word per sensor, copied whole when the host
	// interface is idle; a newer result overwrites a staged one not yet shown
	logic [2:0] pend_q;
	logic [2:0] pend_d;
	logic [RESULT_W-1:0] stage_q [3];
	logic [RESULT_W-1:0] stage_d [3];
	logic [RESULT_W-1:0] result_q [3];
	logic [RESULT_W-1:0] result_d [3];

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pend_d[i] = pend_q[i];
			stage_d[i] = stage_q[i];
			result_d[i] = result_q[i];
			if (!host_xfer_busy && pend_q[i]) begin
				result_d[i] = stage_q[i];
				pend_d[i] = 1'b0;
			end
			// a result arriving on the commit cycle stays pending
			if (state_q == temp_monitor_pkg::ST_SCALE && sens_q == 2'(i)) begin
				stage_d[i] = scaled;
				pend_d[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pend_q <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				stage_q[i] <= `TM_RESULT_RESET;
				result_q[i] <= `TM_RESULT_RESET;
			end
		end else begin
			pend_q <= pend_d;
			for (int i = 0; i < 3; i++) begin
				stage_q[i] <= stage_d[i];
				result_q[i] <= result_d[i];
			end
		end
	end

	assign local_sensor_result = result_q[0];
	assign remote_sensor_one_result = result_q[1];
	assign remote_sensor_two_result = result_q[2];

endmodule

`default_nettype wire

// >>> test/temp_monitor_sva.sv
// port assertions for the temperature monitor
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_sva (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic local_sensor_enable,
	input wire logic remote_one_enable,
	input wire logic remote_two_enable,
	input wire logic series_resistance_cancel,
	input wire logic ideality_write,
	input wire logic [7:0] ideality_wdata,
	input wire logic [7:0] ideality_correction,
	input wire logic host_xfer_busy,
	input wire logic conv_start,
	input wire logic [1:0] conv_sensor,
	input wire logic conv_rc_active,
	input wire logic [11:0] local_sensor_result,
	input wire logic cycle_done
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// enables as seen in the select cycle that precedes a launch
	logic [2:0] en_q;
	always_ff @(posedge clk_sys) begin
		en_q <= {remote_two_enable, remote_one_enable, local_sensor_enable};
	end
	start_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("launch longer than one cycle");
	enabled_only_a: assert property (conv_start |-> en_q[conv_sensor])
		else $error("disabled sensor launched");
	rc_follow_a: assert property (conv_start && conv_sensor != 2'h0
		|-> conv_rc_active == $past(series_resistance_cancel))
		else $error("cancellation flag wrong");
	rc_local_a: assert property (conv_start && conv_sensor == 2'h0
		|-> !conv_rc_active)
		else $error("cancellation active for local sensor");
	result_freeze_a: assert property (host_xfer_busy
		|=> $stable(local_sensor_result))
		else $error("result moved during host transfer");
	corr_load_a: assert property (ideality_write
		|=> ideality_correction == $past(ideality_wdata))
		else $error("correction not loaded");
	corr_hold_a: assert property (!ideality_write
		|=> $stable(ideality_correction))
		else $error("correction changed unasked");
	reset_zero_a: assert property ($fell(sys_rst)
		|-> ideality_correction == 8'h00 && local_sensor_result == 12'h000)
		else $error("nonzero value after reset");
	next_cycle_a: assert property (cycle_done |-> ##[1:4] conv_start)
		else $error("no relaunch after cycle end");
endmodule
bind temp_monitor temp_monitor_sva chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.local_sensor_enable(local_sensor_enable),
	.remote_one_enable(remote_one_enable),
	.remote_two_enable(remote_two_enable),
	.series_resistance_cancel(series_resistance_cancel),
	.ideality_write(ideality_write), .ideality_wdata(ideality_wdata),
	.ideality_correction(ideality_correction),
	.host_xfer_busy(host_xfer_busy), .conv_start(conv_start),
	.conv_sensor(conv_sensor), .conv_rc_active(conv_rc_active),
	.local_sensor_result(local_sensor_result), .cycle_done(cycle_done));
`default_nettype wire

// >>> test/temp_monitor_test.sv
// self-checking bench for the temperature monitor
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_test;
	logic clk_sys = 0;
	logic sys_rst = 1;
	logic l_en = 1, r1_en = 1, r2_en = 1, rc = 1, iw = 0, busy = 0, cd = 0;
	logic [7:0] wd = 8'h00, corr;
	logic [11:0] cc = 12'h000, res0, res1, res2;
	logic [1:0] sel;
	logic cs, crc, cyc, sb;
	int n_errors = 0;
	int tests_run = 0;
	temp_monitor uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.local_sensor_enable(l_en), .remote_one_enable(r1_en),
		.remote_two_enable(r2_en), .series_resistance_cancel(rc),
		.ideality_write(iw), .ideality_wdata(wd),
		.ideality_correction(corr), .host_xfer_busy(busy),
		.conv_start(cs), .conv_sensor(sel), .conv_rc_active(crc),
		.conv_done(cd), .conv_code(cc), .local_sensor_result(res0),
		.remote_sensor_one_result(res1), .remote_sensor_two_result(res2),
		.cycle_done(cyc), .scan_busy(sb));
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// remote scaling in eighths, truncated toward zero
	function automatic logic [11:0] scale(int raw, int n);
		return 12'(((raw + 2185) * (300 - n)) / 300 - 2185);
	endfunction
	task automatic restart(logic [2:0] en, logic r);
		@(posedge clk_sys);
		sys_rst <= 1;
		{r2_en, r1_en, l_en} <= en;
		rc <= r;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 0;
	endtask
	// sampled at the falling edge so a one-cycle launch is never missed
	task automatic conv(logic [1:0] s, logic r, logic [11:0] code);
		int i;
		i = 0;
		do begin
			@(negedge clk_sys);
			i++;
		end while (cs !== 1'b1 && i < 40);
		chk("start", 12'h1, {11'h0, cs});
		chk("sensor", {10'h0, s}, {10'h0, sel});
		chk("scan_busy", 12'h1, {11'h0, sb});
		chk("rc", {11'h0, r & (s != 2'h0)}, {11'h0, crc});
		repeat (3) @(posedge clk_sys);
		cd <= 1;
		cc <= code;
		@(posedge clk_sys);
		cd <= 0;
	endtask
	task automatic wait_cycle();
		int i;
		i = 0;
		do begin
			@(negedge clk_sys);
			i++;
		end while (cyc !== 1'b1 && i < 20);
		chk("cycle_done", 12'h1, {11'h0, cyc});
	endtask
	task automatic t_full();
		restart(3'h7, 1);
		@(negedge clk_sys);
		chk("corr", 12'h000, {4'h0, corr});
		chk("res0", 12'h000, res0);
		chk("idle", 12'h000, {11'h0, sb});
		conv(2'h0, 1, 12'h0c8);
		conv(2'h1, 1, 12'hf38);
		conv(2'h2, 1, 12'h4b0);
		wait_cycle();
		chk("res0", 12'h0c8, res0);
		chk("res1", 12'hf38, res1);
		chk("res2", 12'h4b0, res2);
		conv(2'h0, 1, 12'h7ff);
	endtask
	task automatic t_skip();
		restart(3'h4, 0);
		conv(2'h2, 0, 12'h800);
		wait_cycle();
		conv(2'h2, 0, 12'h320);
		wait_cycle();
		chk("res0", 12'h000, res0);
		chk("res1", 12'h000, res1);
		chk("res2", 12'h320, res2);
	endtask
	task automatic t_ideal();
		restart(3'h7, 1);
		iw <= 1;
		wd <= 8'h80;
		@(posedge clk_sys);
		iw <= 0;
		conv(2'h0, 1, 12'h0c8);
		conv(2'h1, 1, 12'h0c8);
		conv(2'h2, 1, 12'h7ff);
		wait_cycle();
		chk("corr", 12'h080, {4'h0, corr});
		chk("res0", 12'h0c8, res0);
		chk("res1", scale(200, -128), res1);
		// scaled far above the code range, so the result saturates
		chk("res2", 12'h7ff, res2);
	endtask
	task automatic t_freeze();
		restart(3'h1, 1);
		busy <= 1;
		conv(2'h0, 1, 12'h190);
		repeat (10) @(negedge clk_sys);
		chk("held", 12'h000, res0);
		chk("corr", 12'h000, {4'h0, corr});
		@(posedge clk_sys);
		busy <= 0;
		repeat (3) @(negedge clk_sys);
		chk("res0", 12'h190, res0);
	endtask
	initial begin
		#100us;
		n_errors++;
		conclude();
	end
	initial begin
		t_full();
		t_skip();
		t_ideal();
		t_freeze();
		conclude();
	end
endmodule
`default_nettype wire
